// *** hdl/field_lock_pkg.sv ***
// Constants, types and register map of the field strength and angle lock block
// What this block does
// (R1) The weak-field pin is high while the gain value is below 3FH and low once it sits at 3FH.
// (R2) The 6-bit gain value sits in bits D12 down to D7 of the angle read frame.
// (R3) The gain loop holds the signal amplitude constant, rising as the field weakens and falling as it strengthens.
// (R4) A 3-bit sensitivity of eight steps is the gain field of the configuration and steers the gain path.
// (R5) The lock flag is set once the tracking converter has reached the magnet angle.
// (R6) From any start the converter locks within at most 128 position steps of about 1.15 us plus one more step to set lock.
// (R7) Once locked the converter follows a moving magnet with one 1.15 us step per angle update.
// (R8) Low power freezes the converter position and tracking resumes from that position, not from zero.
// (R9) After resuming, one step per position of difference is taken before lock is set again.
// (R10) The PWM angle output runs at about 1.95 kHz with one angle reading per period.
// (R11) The host must leave more than 500 ns between sclk rises, as sdo moves 5 clocks after a rise, and one angle read returns a 21-bit frame.
// (R12) The lock flag reads high while the angle is valid and low while the converter is unlocked.
// (R13) The host enters low power with the configuration write command 17H.
// (R14) Gain and lock in a frame are sampled at the frame start so the frame is self-consistent.
`default_nettype none
package field_lock_pkg;
  // Timing
  localparam int CLK_FREQ_HZ = 10_000_000;
  localparam int CLK_PERIOD_NS = 100;
  localparam int TRACK_STEP_NS = 1150;
  localparam int TRACK_STEP_CYC = (TRACK_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PWM_FREQ_CHZ = 195000;
  localparam int PWM_PERIOD_CYC = CLK_FREQ_HZ / PWM_FREQ_CHZ * 100 + (CLK_FREQ_HZ % PWM_FREQ_CHZ) * 100 / PWM_FREQ_CHZ;
  localparam int PWM_STEP_NS = 2000;
  localparam int PWM_STEP_CYC = PWM_STEP_NS / CLK_PERIOD_NS;
  // Gain loop
  localparam logic [5:0] AGC_MAX = 6'h3F;
  localparam logic [5:0] AGC_MIN = 6'h00;
  localparam logic [5:0] AGC_RESET = 6'h20;
  localparam logic [14:0] AMP_TARGET = 15'h0800;
  localparam logic [2:0] SENS_RESET = 3'h0;
  // Serial link
  localparam int CMD_W = 5;
  localparam logic [4:0] CMD_READ_ANGLE = 5'h00;
  localparam logic [4:0] CMD_WRITE_CONFIG = 5'h17;
  localparam int FRAME_W = 21;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h08;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h0C;
  // Interrupt bits
  localparam int IRQ_W = 4;
  localparam int IRQ_LOCK_GAIN = 0;
  localparam int IRQ_LOCK_LOSS = 1;
  localparam int IRQ_WEAK = 2;
  localparam int IRQ_FRAME = 3;

  typedef struct packed {
    logic [2:0] sens;
    logic low_power;
  } ctrl_t;

  typedef struct packed {
    logic sclk;
    logic cs_n;
    logic sdi;
  } link_pins_t;

  localparam link_pins_t LINK_IDLE = 3'h2;

  typedef enum logic [2:0] {SER_IDLE, SER_CMD, SER_SEND, SER_CFG, SER_DONE} ser_state_t;
endpackage
`default_nettype wire

// *** hdl/field_strength_and_angle_lock.sv ***
// Gain loop, tracking angle converter, lock flag, serial frame, PWM and register slave
`default_nettype none
module field_strength_and_angle_lock #(
  parameter int PWM_PERIOD_CYC = field_lock_pkg::PWM_PERIOD_CYC
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Sensor front end
  input wire logic [7:0] angle_meas_i,
  input wire logic [7:0] field_i,
  // Serial link pins
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic sdi_i,
  output logic sdo_o,
  output logic sdo_oe_o,
  // Indicators
  output logic weak_field_indicator_pin_o,
  output logic pwm_o,
  output logic irq_o
);
  field_lock_pkg::ctrl_t ctrl_reg;
  logic [5:0] agc_reg;
  logic [7:0] pos_reg;
  logic lock_reg;
  logic lock_d_reg;
  logic lp_serial_reg;
  logic [3:0] step_cnt_reg;
  localparam int IRQ_W_L = field_lock_pkg::IRQ_W;
  logic [IRQ_W_L-1:0] irq_stat_reg;
  logic [IRQ_W_L-1:0] irq_mask_reg;

  // Three-stage sampling of the link pins
  field_lock_pkg::link_pins_t s1_reg, s2_reg, s3_reg, filt_reg, filt_d_reg;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_reg <= field_lock_pkg::LINK_IDLE;
      s2_reg <= field_lock_pkg::LINK_IDLE;
      s3_reg <= field_lock_pkg::LINK_IDLE;
      filt_reg <= field_lock_pkg::LINK_IDLE;
      filt_d_reg <= field_lock_pkg::LINK_IDLE;
    end else begin
      s1_reg <= {sclk_i, cs_n_i, sdi_i};
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      filt_reg <= (~(s2_reg ^ s3_reg) & s3_reg) | ((s2_reg ^ s3_reg) & filt_reg);
      filt_d_reg <= filt_reg;
    end
  end

  wire sclk_rise = filt_reg.sclk & ~filt_d_reg.sclk;
  wire cs_active = ~filt_reg.cs_n;

  // Tracking step divider
  wire step_tick = (step_cnt_reg == 4'(field_lock_pkg::TRACK_STEP_CYC - 1));
  always_ff @(posedge clk_i) begin
    if (rst_i || step_tick) begin
      step_cnt_reg <= 4'h0;
    end else begin
      step_cnt_reg <= step_cnt_reg + 4'h1;
    end
  end

  wire low_power = ctrl_reg.low_power | lp_serial_reg;
  wire run_step = step_tick & ~low_power;

  // Gain loop: total gain is the loop value plus the sensitivity offset
  wire [6:0] gain_total = {1'b0, agc_reg} + {1'b0, ctrl_reg.sens, 3'h0}; // R4
  // Both factors widened first so the product never wraps
  wire [14:0] amp = {7'h00, field_i} * {8'h00, gain_total};
  wire agc_up = (amp < field_lock_pkg::AMP_TARGET) && (agc_reg != field_lock_pkg::AGC_MAX);
  wire agc_dn = (amp > field_lock_pkg::AMP_TARGET) && (agc_reg != field_lock_pkg::AGC_MIN);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      agc_reg <= field_lock_pkg::AGC_RESET;
    end else if (run_step && agc_up) begin
      agc_reg <= agc_reg + 6'h01; // R3
    end else if (run_step && agc_dn) begin
      agc_reg <= agc_reg - 6'h01; // R3
    end
  end

  // Tracking converter: one position per step along the shorter way round
  wire [7:0] diff = angle_meas_i - pos_reg;
  wire on_target = (diff == 8'h00);
  wire near_target = (diff == 8'h01) || (diff == 8'hFF);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pos_reg <= 8'h00;
      lock_reg <= 1'b0;
    end else if (low_power) begin
      lock_reg <= 1'b0; // R8 R12
    end else if (step_tick) begin
      if (on_target) begin
        lock_reg <= 1'b1; // R5 R9 R12
      end else begin
        pos_reg <= diff[7] ? pos_reg - 8'h01 : pos_reg + 8'h01; // R6 R9
        lock_reg <= lock_reg & near_target; // R7 R12
      end
    end
  end

  // Serial link: 5 command bits, then a 21-bit frame or one config bit
  field_lock_pkg::ser_state_t ser_state_reg;
  logic [4:0] cmd_reg;
  logic [4:0] bit_cnt_reg;
  logic [field_lock_pkg::FRAME_W-1:0] shift_reg;
  logic frame_done;
  wire [4:0] cmd_full = {cmd_reg[3:0], filt_reg.sdi};
  wire [field_lock_pkg::FRAME_W-1:0] frame_now = {lock_reg, 5'h00, pos_reg[7], 1'b0, agc_reg, pos_reg[6:0]}; // R2
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ser_state_reg <= field_lock_pkg::SER_IDLE;
      cmd_reg <= 5'h00;
      bit_cnt_reg <= 5'h00;
      shift_reg <= '0;
      sdo_o <= 1'b0;
      sdo_oe_o <= 1'b0;
      lp_serial_reg <= 1'b0;
      frame_done <= 1'b0;
    end else begin
      frame_done <= 1'b0;
      if (!cs_active) begin
        ser_state_reg <= field_lock_pkg::SER_IDLE;
        sdo_oe_o <= 1'b0;
      end else begin
        unique case (ser_state_reg)
          field_lock_pkg::SER_IDLE: begin
            ser_state_reg <= field_lock_pkg::SER_CMD;
            bit_cnt_reg <= 5'h00;
          end
          field_lock_pkg::SER_CMD: if (sclk_rise) begin
            cmd_reg <= cmd_full;
            bit_cnt_reg <= bit_cnt_reg + 5'h01;
            if (bit_cnt_reg == 5'(field_lock_pkg::CMD_W - 1)) begin
              bit_cnt_reg <= 5'h00;
              if (cmd_full == field_lock_pkg::CMD_READ_ANGLE) begin
                shift_reg <= {frame_now[field_lock_pkg::FRAME_W-2:0], 1'b0}; // R14
                sdo_o <= frame_now[field_lock_pkg::FRAME_W-1]; // R14
                sdo_oe_o <= 1'b1;
                ser_state_reg <= field_lock_pkg::SER_SEND;
              end else if (cmd_full == field_lock_pkg::CMD_WRITE_CONFIG) begin
                ser_state_reg <= field_lock_pkg::SER_CFG; // R13
              end else begin
                ser_state_reg <= field_lock_pkg::SER_DONE;
              end
            end
          end
          field_lock_pkg::SER_SEND: if (sclk_rise) begin
            if (bit_cnt_reg == 5'(field_lock_pkg::FRAME_W - 1)) begin
              frame_done <= 1'b1; // R11
              sdo_oe_o <= 1'b0;
              ser_state_reg <= field_lock_pkg::SER_DONE;
            end else begin
              sdo_o <= shift_reg[field_lock_pkg::FRAME_W-1];
              shift_reg <= {shift_reg[field_lock_pkg::FRAME_W-2:0], 1'b0};
              bit_cnt_reg <= bit_cnt_reg + 5'h01;
            end
          end
          field_lock_pkg::SER_CFG: if (sclk_rise) begin
            lp_serial_reg <= filt_reg.sdi; // R8 R13
            ser_state_reg <= field_lock_pkg::SER_DONE;
          end
          field_lock_pkg::SER_DONE: begin
            ser_state_reg <= field_lock_pkg::SER_DONE;
          end
        endcase
      end
    end
  end

  // Weak-field pin follows the gain value
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      weak_field_indicator_pin_o <= 1'b1;
    end else begin
      weak_field_indicator_pin_o <= (agc_reg != field_lock_pkg::AGC_MAX); // R1
    end
  end

  // PWM: angle latched once per period, high for (angle + 1) steps
  logic [12:0] pwm_cnt_reg;
  logic [12:0] pwm_hi_reg;
  wire pwm_wrap = (pwm_cnt_reg == 13'(PWM_PERIOD_CYC - 1));
  wire [12:0] pwm_hi_now = 13'(({5'h00, pos_reg} + 13'h0001) * 13'(field_lock_pkg::PWM_STEP_CYC));
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pwm_cnt_reg <= 13'h0000;
      pwm_hi_reg <= 13'h0000;
      pwm_o <= 1'b0;
    end else begin
      pwm_cnt_reg <= pwm_wrap ? 13'h0000 : pwm_cnt_reg + 13'h0001; // R10
      if (pwm_wrap) begin
        pwm_hi_reg <= pwm_hi_now; // R10
      end
      pwm_o <= (pwm_cnt_reg < pwm_hi_reg);
    end
  end

  // Events for the interrupt status
  wire weak_now = (agc_reg == field_lock_pkg::AGC_MAX);
  logic weak_d_reg;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lock_d_reg <= 1'b0;
      weak_d_reg <= 1'b0;
    end else begin
      lock_d_reg <= lock_reg;
      weak_d_reg <= weak_now;
    end
  end
  logic [IRQ_W_L-1:0] irq_ev;
  always_comb begin
    irq_ev = '0;
    irq_ev[field_lock_pkg::IRQ_LOCK_GAIN] = lock_reg & ~lock_d_reg;
    irq_ev[field_lock_pkg::IRQ_LOCK_LOSS] = ~lock_reg & lock_d_reg;
    irq_ev[field_lock_pkg::IRQ_WEAK] = weak_now & ~weak_d_reg;
    irq_ev[field_lock_pkg::IRQ_FRAME] = frame_done;
  end

  // Wishbone slave: one wait state, unmapped reads give zero
  wire wb_hit = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wb_wr = wb_hit & wb_we_i & wb_sel_i[0];
  wire sel_ctrl = (wb_adr_i == field_lock_pkg::OFS_CTRL);
  wire sel_status = (wb_adr_i == field_lock_pkg::OFS_STATUS);
  wire sel_istat = (wb_adr_i == field_lock_pkg::OFS_IRQ_STAT);
  wire sel_imask = (wb_adr_i == field_lock_pkg::OFS_IRQ_MASK);
  wire [31:0] status_word = {8'h00, pos_reg, 2'h0, agc_reg, 6'h00, low_power, lock_reg}; // R12
  wire [31:0] rd_data = sel_ctrl ? {28'h0000000, ctrl_reg} :
                        sel_status ? status_word :
                        sel_istat ? {28'h0000000, irq_stat_reg} :
                        sel_imask ? {28'h0000000, irq_mask_reg} : 32'h00000000;
  wire [IRQ_W_L-1:0] irq_clr = (wb_wr && sel_istat) ? wb_dat_i[IRQ_W_L-1:0] : '0;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
      ctrl_reg <= {field_lock_pkg::SENS_RESET, 1'b0};
      irq_mask_reg <= '0;
      irq_stat_reg <= '0;
      irq_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_hit;
      if (wb_hit) begin
        wb_dat_o <= rd_data;
      end
      if (wb_wr && sel_ctrl) begin
        ctrl_reg <= wb_dat_i[3:0]; // R4 R8
      end
      if (wb_wr && sel_imask) begin
        irq_mask_reg <= wb_dat_i[IRQ_W_L-1:0];
      end
      // Set wins over a write-one clear in the same cycle
      irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_ev;
      irq_o <= |(irq_stat_reg & irq_mask_reg);
    end
  end
endmodule
`default_nettype wire

// *** tb/field_lock_monitor.sv ***
// Assertions on the ports of the field lock block
`default_nettype none
module field_lock_monitor (
  // Watched ports
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic cs_n_i,
  input wire logic sdo_oe_o,
  input wire logic weak_field_indicator_pin_o,
  input wire logic pwm_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_ack_due; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  a_ack_due: assert property (p_ack_due) else $error("no ack");
  property p_ack_once; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_once: assert property (p_ack_once) else $error("ack too long");
  property p_ack_why; $rose(wb_ack_o) |-> $past(wb_cyc_i) && $past(wb_stb_i); endproperty
  a_ack_why: assert property (p_ack_why) else $error("ack without request");
  property p_rst_out;
    disable iff (1'h0) $fell(rst_i) |-> !wb_ack_o && !sdo_oe_o && !pwm_o && weak_field_indicator_pin_o;
  endproperty
  a_rst_out: assert property (p_rst_out) else $error("bad outputs after reset");
  property p_pwm_hi; $rose(pwm_o) |-> pwm_o [*8]; endproperty
  a_pwm_hi: assert property (p_pwm_hi) else $error("pwm pulse short");
  property p_pwm_lo; $fell(pwm_o) |-> !pwm_o [*8]; endproperty
  a_pwm_lo: assert property (p_pwm_lo) else $error("pwm gap short");
  property p_oe_cs; $rose(sdo_oe_o) |-> !$past(cs_n_i, 3); endproperty
  a_oe_cs: assert property (p_oe_cs) else $error("sdo enabled unselected");
  property p_oe_off; cs_n_i [*8] |-> !sdo_oe_o; endproperty
  a_oe_off: assert property (p_oe_off) else $error("sdo enabled while idle");
endmodule
bind field_strength_and_angle_lock field_lock_monitor field_lock_monitor_i (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
  .wb_ack_o, .cs_n_i, .sdo_oe_o, .weak_field_indicator_pin_o, .pwm_o);
`default_nettype wire

// *** tb/field_lock_host.sv ***
// Host model that drives the serial link and reads frames
`default_nettype none
module field_lock_host (
  // Device side
  input wire logic clk_i,
  input wire logic sdo_i,
  input wire logic sdo_oe_i,
  // Link pins
  output logic sclk_o,
  output logic cs_n_o,
  output logic sdi_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // Link clock stands low between frames
  initial {sclk_o, cs_n_o, sdi_o} = 3'h3;
  // Four clocks per half period give the 800 ns link clock
  task automatic half();
    repeat (4) @(posedge clk_i);
  endtask
  // Released sdo reads inverted so stale data never passes
  task automatic xfer(input logic [4:0] cmd, input int n, input logic cfg, output logic [20:0] q);
    logic [5:0] bits;
    bits = {cmd, cfg};
    q = 21'h0;
    @(posedge clk_i);
    cs_n_o <= 1'h0;
    for (int i = 0; i < 5 + n; i++) begin
      sdi_o <= (i < 6) ? bits[5 - i] : !sdi_o;
      half();
      sclk_o <= 1'h1;
      if (i >= 5) q = {q[19:0], sdo_oe_i ? sdo_i : !sdo_i};
      half();
      sclk_o <= 1'h0;
    end
    half();
    cs_n_o <= 1'h1;
    sdi_o <= !sdi_o;
    half();
  endtask
endmodule
`default_nettype wire

// *** tb/testbench.sv ***
// Self-checking bench for the field strength and angle lock block
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 1'h0, rst_i = 1'h1, wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0;
  logic [7:0] wb_adr_i = 8'h00, angle_meas_i = 8'h80, field_i = 8'h40;
  logic [3:0] wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, st;
  logic [20:0] fr;
  logic wb_ack_o, sclk_i, cs_n_i, sdi_i, sdo_o, sdo_oe_o, weak_field_indicator_pin_o, pwm_o, irq_o;
  int n_fail = 0, checks_done = 0;
  always #50 clk_i = ~clk_i;
  field_strength_and_angle_lock field_strength_and_angle_lock_i (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .angle_meas_i, .field_i, .sclk_i, .cs_n_i, .sdi_i,
    .sdo_o, .sdo_oe_o, .weak_field_indicator_pin_o, .pwm_o, .irq_o);
  field_lock_host field_lock_host_i (.clk_i, .sdo_i(sdo_o), .sdo_oe_i(sdo_oe_o), .sclk_o(sclk_i),
    .cs_n_o(cs_n_i), .sdi_o(sdi_i));
  task automatic results();
    if (n_fail == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) n_fail++;
    if (got !== exp) $display("FAIL %s expected %h seen %h", nm, exp, got);
  endtask
  // One classic cycle, read data lands in st
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'h3, w, a, d};
    for (i = 0; i < 20 && wb_ack_o !== 1'h1; i++) @(posedge clk_i);
    chk("ack", 32'h1, {31'h0, wb_ack_o});
    if (wb_ack_o !== 1'h1) results();
    st = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'h0;
    @(posedge clk_i);
  endtask
  // Bounded status poll until masked bits match
  task automatic poll(input logic [31:0] m, input logic [31:0] v, input int lim);
    wb(1'h0, field_lock_pkg::OFS_STATUS, 32'h0);
    for (int i = 1; i < lim && (st & m) !== v; i++) wb(1'h0, field_lock_pkg::OFS_STATUS, 32'h0);
    chk("status", v, st & m);
    if ((st & m) !== v) results();
  endtask
  task automatic t_sens();
    chk("weak", 32'h1, {31'h0, weak_field_indicator_pin_o});
    for (int s = 0; s < 8; s++) begin
      wb(1'h1, field_lock_pkg::OFS_CTRL, 32'(s) << 1);
      wb(1'h0, field_lock_pkg::OFS_CTRL, 32'h0);
      chk("sens", 32'(s) << 1, st);
    end
    wb(1'h0, 8'h10, 32'h0);
    chk("unmapped", 32'h0, st);
  endtask
  task automatic t_lock();
    wb(1'h1, field_lock_pkg::OFS_IRQ_MASK, 32'h1);
    poll(32'h1, 32'h0, 1);
    poll(32'h00FF0001, 32'h00800001, 520);
    chk("irq", 32'h1, {31'h0, irq_o});
    wb(1'h1, field_lock_pkg::OFS_IRQ_STAT, 32'h1);
    chk("irq", 32'h0, {31'h0, irq_o});
    angle_meas_i <= 8'h81;
    poll(32'h00FF0001, 32'h00810001, 12);
    wb(1'h0, field_lock_pkg::OFS_IRQ_STAT, 32'h0);
    chk("lost", 32'h0, st & 32'h2);
  endtask
  // Gain settles where field times gain meets the target
  task automatic t_gain();
    field_i <= 8'hFF;
    wb(1'h1, field_lock_pkg::OFS_CTRL, 32'h0);
    poll(32'h3E00, 32'h0800, 300);
    chk("weak", 32'h1, {31'h0, weak_field_indicator_pin_o});
    wb(1'h1, field_lock_pkg::OFS_CTRL, 32'hE);
    poll(32'h3F00, 32'h0000, 100);
    field_i <= 8'h01;
    wb(1'h1, field_lock_pkg::OFS_CTRL, 32'h0);
    poll(32'h3F00, 32'h3F00, 300);
    chk("weak", 32'h0, {31'h0, weak_field_indicator_pin_o});
    wb(1'h0, field_lock_pkg::OFS_IRQ_STAT, 32'h0);
    chk("weakirq", 32'h4, st & 32'h4);
  endtask
  task automatic t_frame();
    field_lock_host_i.xfer(field_lock_pkg::CMD_READ_ANGLE, 21, 1'h0, fr);
    chk("frame", {11'h0, 1'h1, 5'h00, angle_meas_i[7], 1'h0, 6'h3F, angle_meas_i[6:0]}, {11'h0, fr});
    wb(1'h0, field_lock_pkg::OFS_IRQ_STAT, 32'h0);
    chk("sent", 32'h8, st & 32'h8);
  endtask
  task automatic t_sleep();
    field_lock_host_i.xfer(field_lock_pkg::CMD_WRITE_CONFIG, 1, 1'h1, fr);
    poll(32'h00FF0003, 32'h00810002, 1);
    angle_meas_i <= 8'h91;
    repeat (60) @(posedge clk_i);
    poll(32'h00FF0003, 32'h00810002, 1);
    field_lock_host_i.xfer(field_lock_pkg::CMD_WRITE_CONFIG, 1, 1'h0, fr);
    poll(32'h00F00001, 32'h00800000, 1);
    poll(32'h00FF0001, 32'h00910001, 120);
    // Register path into low power as well
    wb(1'h1, field_lock_pkg::OFS_CTRL, 32'h1);
    poll(32'h00FF0003, 32'h00910002, 1);
    wb(1'h1, field_lock_pkg::OFS_CTRL, 32'h0);
    poll(32'h00FF0003, 32'h00910001, 10);
  endtask
  // Position 91h held from here on, so the next full period is known
  task automatic t_pwm();
    int n, hi, lo;
    for (n = 0; n < 6000 && pwm_o !== 1'h1; n++) @(posedge clk_i);
    for (hi = 0; hi < 6000 && pwm_o === 1'h1; hi++) @(posedge clk_i);
    for (lo = 0; lo < 6000 && pwm_o !== 1'h1; lo++) @(posedge clk_i);
    chk("pwm_high", 32'((32'h91 + 1) * field_lock_pkg::PWM_STEP_CYC), 32'(hi));
    chk("pwm_period", 32'(field_lock_pkg::PWM_PERIOD_CYC), 32'(hi + lo));
  endtask
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'h0;
    @(posedge clk_i);
    t_sens();
    t_lock();
    t_gain();
    t_frame();
    t_sleep();
    t_pwm();
    results();
  end
endmodule
`default_nettype wire
